// ==== logic/afpd_pkg.sv ====
`default_nettype none
// ======================================================================
// shared constants for amplifier fault protection
package afpd_pkg;
   localparam int NUM_CH = 2;
   // retry period of a shorted channel
   localparam int RETRY_MS = 50;
   localparam int CLK_MHZ = 250;
   localparam int RETRY_CYC = RETRY_MS * 1000 * CLK_MHZ;
   // status word field positions, per 7-bit channel field
   localparam int ST_SHORT_BIT = 0;
   localparam int ST_SUPPLY_BIT = 1;
   localparam int ST_OFFSET_BIT = 2;
   localparam int ST_HOT_BIT = 3;
   localparam int ST_WARN_BIT = 4;
   localparam int ST_HIGHV_BIT = 5;
   localparam int ST_LOWV_BIT = 6;
   localparam int ST_W = 7;
   localparam logic [ST_W-1:0] ST_RESET = 7'h00;
   // start-up sequence states
   typedef enum logic [1:0]
   {
      AFPD_OFF   = 2'b00,
      AFPD_CHECK = 2'b01,
      AFPD_RUN   = 2'b10
   } afpd_seq_t;
endpackage : afpd_pkg
`default_nettype wire

// ==== logic/afpd_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module afpd_top
   import afpd_pkg::*;
#(
   parameter int RETRY_CYCLES = afpd_pkg::RETRY_CYC
)
(
   // clock and reset
   input  wire logic                          clock_in,
   input  wire logic                          rst_b_in,
   // mode controls
   input  wire logic                          enable_in,
   input  wire logic                          bus_mode_in,
   input  wire logic                          sel_offset_fault_indicator_pin_in,
   input  wire logic                          sel_clip_in,
   input  wire logic                          sel_warn_in,
   input  wire logic                          start_req_in,
   // analog comparator inputs
   input  wire logic                          temp_fold_in,
   input  wire logic                          temp_hot_in,
   input  wire logic                          temp_warn_in,
   input  wire logic                          low_supply_in,
   input  wire logic                          high_supply_in,
   input  wire logic                          clip_in,
   input  wire logic [afpd_pkg::NUM_CH-1:0]   cur_limit_in,
   input  wire logic [afpd_pkg::NUM_CH-1:0]   load_short_in,
   input  wire logic [afpd_pkg::NUM_CH-1:0]   supply_short_in,
   input  wire logic [afpd_pkg::NUM_CH-1:0]   offset_in,
   input  wire logic [afpd_pkg::NUM_CH-1:0]   out_shorted_in,
   // status read port
   input  wire logic                          status_rd_in,
   output logic [afpd_pkg::NUM_CH*afpd_pkg::ST_W-1:0] status_out,
   output logic                               status_valid_out,
   // power stage controls
   output logic                               gain_reduce_out,
   output logic                               stage_on_out,
   output logic [afpd_pkg::NUM_CH-1:0]        chan_on_out,
   output logic [afpd_pkg::NUM_CH-1:0]        cur_limit_out,
   // open-drain indicator pins
   output logic                               fault_pin_out,
   output logic                               fault_pin_oe_b_out,
   output logic                               sat_pin_out,
   output logic                               sat_pin_oe_b_out
);
   import afpd_pkg::*;

   localparam int NIN = 6 + 5 * NUM_CH;
   localparam int RW = $clog2(RETRY_CYCLES + 1);

   // ===================================================================
   // input synchronisers
   logic [NIN-1:0] raw_w;
   logic [NIN-1:0] meta_r;
   logic [NIN-1:0] sync_r;

   assign raw_w = {temp_fold_in, temp_hot_in, temp_warn_in, low_supply_in,
                   high_supply_in, clip_in, cur_limit_in, load_short_in,
                   supply_short_in, offset_in, out_shorted_in};

   // two flops per comparator line
   always_ff @(posedge clock_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         meta_r <= '0;
         sync_r <= '0;
      end
      else
      begin
         meta_r <= raw_w;
         sync_r <= meta_r;
      end
   end

   logic              fold_s, hot_s, warn_s, lowv_s, highv_s, clip_s;
   logic [NUM_CH-1:0] ilim_s, lsh_s, ssh_s, ofs_s, osh_s;
   assign {fold_s, hot_s, warn_s, lowv_s, highv_s, clip_s,
           ilim_s, lsh_s, ssh_s, ofs_s, osh_s} = sync_r;

   // ===================================================================
   // start-up sequence with pre-switching check
   afpd_seq_t seq_r;
   logic      por_r;

   always_ff @(posedge clock_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
         seq_r <= AFPD_OFF;
      else if (!enable_in)
         seq_r <= AFPD_OFF;
      else
      begin
         unique case (seq_r)
            AFPD_OFF:
               if (start_req_in)
                  seq_r <= AFPD_CHECK;
            AFPD_CHECK:
               if (osh_s == '0)
                  seq_r <= AFPD_RUN;
            AFPD_RUN:
               if (!start_req_in)
                  seq_r <= AFPD_OFF;
            default:
               seq_r <= AFPD_OFF;
         endcase
      end
   end

   // power-on reset indication, first cycle after release
   always_ff @(posedge clock_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
         por_r <= 1'b1;
      else
         por_r <= 1'b0;
   end

   // ===================================================================
   // per-channel short shutdown and retry
   logic [NUM_CH-1:0] ch_off_r;
   logic [NUM_CH-1:0] sup_hold_r;
   logic [NUM_CH-1:0] short_w;

   assign short_w = lsh_s | ssh_s;

   genvar g;
   generate
      for (g = 0; g < NUM_CH; g++)
      begin : g_ch
         logic [RW-1:0] tmr_r;

         // switch off on short, retry after the period; a supply short retries only once ssh_s and osh_s clear
         always_ff @(posedge clock_in or negedge rst_b_in)
         begin
            if (!rst_b_in)
            begin
               ch_off_r[g]   <= 1'b0;
               sup_hold_r[g] <= 1'b0;
               tmr_r         <= '0;
            end
            else if (!ch_off_r[g])
            begin
               if (short_w[g] && seq_r == AFPD_RUN)
               begin
                  ch_off_r[g]   <= 1'b1;
                  sup_hold_r[g] <= ssh_s[g];
                  tmr_r         <= RW'(RETRY_CYCLES - 1);
               end
            end
            else if (tmr_r != '0)
               tmr_r <= tmr_r - 1'b1;
            else if (sup_hold_r[g] && (ssh_s[g] || osh_s[g]))
               tmr_r <= '0;
            else
            begin
               ch_off_r[g]   <= 1'b0;
               sup_hold_r[g] <= 1'b0;
            end
         end
      end
   endgenerate

   // stage and channel enables
   always_comb
   begin
      stage_on_out    = (seq_r == AFPD_RUN) && !hot_s;
      chan_on_out     = stage_on_out ? ~ch_off_r : '0;
      cur_limit_out   = stage_on_out ? ilim_s : '0;
      gain_reduce_out = fold_s && enable_in;
   end

   // ===================================================================
   // fault latches, cleared by read; set wins over clear
   logic [NUM_CH*ST_W-1:0] lat_r;
   logic [NUM_CH*ST_W-1:0] ev_w;
   logic                   mon_w;
   logic                   rd_w;

   assign mon_w = (seq_r != AFPD_OFF);
   assign rd_w  = status_rd_in && enable_in;

   generate
      for (g = 0; g < NUM_CH; g++)
      begin : g_ev
         always_comb
         begin
            ev_w[g*ST_W +: ST_W]                 = ST_RESET;
            ev_w[g*ST_W + ST_SHORT_BIT]          = lsh_s[g] | ilim_s[g];
            ev_w[g*ST_W + ST_SUPPLY_BIT]         = ssh_s[g] | osh_s[g];
            ev_w[g*ST_W + ST_OFFSET_BIT]         = ofs_s[g] & mon_w;
            ev_w[g*ST_W + ST_HOT_BIT]            = hot_s;
            ev_w[g*ST_W + ST_WARN_BIT]           = warn_s;
            ev_w[g*ST_W + ST_HIGHV_BIT]          = highv_s;
            ev_w[g*ST_W + ST_LOWV_BIT]           = lowv_s;
         end
      end
   endgenerate

   // latch events; a read clears what was returned
   always_ff @(posedge clock_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
         lat_r <= {NUM_CH{ST_RESET}};
      else if (rd_w)
         lat_r <= ev_w;
      else
         lat_r <= lat_r | ev_w;
   end

   // read data: the previously latched word
   always_ff @(posedge clock_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         status_out       <= '0;
         status_valid_out <= 1'b0;
      end
      else
      begin
         status_valid_out <= rd_w;
         if (rd_w)
            status_out <= lat_r;
      end
   end

   // ===================================================================
   // indicator pins, live state only
   logic fault_w, sat_w;

   always_comb
   begin
      fault_w = por_r || lowv_s || highv_s || hot_s
                || (|short_w) || (|osh_s) || (|ch_off_r)
                || ((|ofs_s) && mon_w
                    && (!bus_mode_in || sel_offset_fault_indicator_pin_in));
      sat_w   = por_r
                || (clip_s && (!bus_mode_in || sel_clip_in))
                || (warn_s && (!bus_mode_in || sel_warn_in));
   end

   // open drain: output low, enable low only while pulling
   always_ff @(posedge clock_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         fault_pin_oe_b_out <= 1'b0;
         sat_pin_oe_b_out   <= 1'b0;
      end
      else
      begin
         fault_pin_oe_b_out <= !fault_w;
         sat_pin_oe_b_out   <= !sat_w;
      end
   end

   assign fault_pin_out = 1'b0;
   assign sat_pin_out   = 1'b0;

   // ===================================================================
   // checks
   a_hot_stage_off: assert property (@(posedge clock_in) disable iff (!rst_b_in)
      hot_s |-> !stage_on_out) else $error("stage on while hot");
   a_limit_keeps_on: assert property (@(posedge clock_in)
      disable iff (!rst_b_in)
      (stage_on_out && ilim_s[0] && !short_w[0] && !ch_off_r[0])
      |-> chan_on_out[0]) else $error("limit stopped channel");
   a_check_holds: assert property (@(posedge clock_in) disable iff (!rst_b_in)
      (seq_r == AFPD_CHECK && osh_s != '0 && enable_in)
      |=> seq_r == AFPD_CHECK) else $error("start past short");
   a_short_pin_low: assert property (@(posedge clock_in)
      disable iff (!rst_b_in)
      (lsh_s[0] && !rd_w) |=> !fault_pin_oe_b_out
      && lat_r[ST_SHORT_BIT]) else $error("short not flagged");
   a_latch_holds: assert property (@(posedge clock_in) disable iff (!rst_b_in)
      (lat_r[ST_SHORT_BIT] && !rd_w) |=> lat_r[ST_SHORT_BIT])
      else $error("latch lost");
   a_read_returns: assert property (@(posedge clock_in)
      disable iff (!rst_b_in)
      rd_w |=> status_out == $past(lat_r)) else $error("bad read");
   a_off_ignores_rd: assert property (@(posedge clock_in)
      disable iff (!rst_b_in)
      !enable_in |=> !status_valid_out && seq_r == AFPD_OFF)
      else $error("active while off");
   a_sat_no_fault: assert property (@(posedge clock_in)
      disable iff (!rst_b_in)
      (!por_r && !clip_s && !warn_s) |=> sat_pin_oe_b_out)
      else $error("sat pin for fault");
   a_retry_wait: assert property (@(posedge clock_in) disable iff (!rst_b_in)
      $rose(ch_off_r[0]) |=> ch_off_r[0] [*8])
      else $error("retry too soon");
   a_fold_gain: assert property (@(posedge clock_in) disable iff (!rst_b_in)
      (fold_s && enable_in) |-> gain_reduce_out)
      else $error("no gain reduce");

   c_short_retry: cover property (@(posedge clock_in) disable iff (!rst_b_in)
      $fell(ch_off_r[0]));
   c_check_block: cover property (@(posedge clock_in) disable iff (!rst_b_in)
      seq_r == AFPD_CHECK && osh_s != '0);
   c_double_read: cover property (@(posedge clock_in) disable iff (!rst_b_in)
      rd_w ##[1:20] rd_w);
endmodule : afpd_top
`default_nettype wire

// ==== test/afpd_host.sv ====
`timescale 1ns/100ps
`default_nettype none
// ======================================================================
// host side: pull-ups on the indicator pins and status read strobes
module afpd_host
(
   // clock
   input  wire logic clock_in,
   // indicator pins from the amplifier
   input  wire logic fault_drv_in,
   input  wire logic fault_oe_b_in,
   input  wire logic sat_drv_in,
   input  wire logic sat_oe_b_in,
   output logic      fault_wire_out,
   output logic      sat_wire_out,
   // status read request
   output logic      rd_out
);
   // released pins float up to the external pull-up level
   assign fault_wire_out = fault_oe_b_in ? 1'b1 : fault_drv_in;
   assign sat_wire_out   = sat_oe_b_in ? 1'b1 : sat_drv_in;
   initial rd_out = 1'b0;
   // one-cycle strobe; live state needs two of these in a row
   task automatic issue_read;
      @(posedge clock_in);
      rd_out <= 1'b1;
      @(posedge clock_in);
      rd_out <= 1'b0;
   endtask : issue_read
endmodule : afpd_host
`default_nettype wire

// ==== test/tb_amp_fault_protection_fault_indicator_pin.sv ====
`timescale 1ns/100ps
`default_nettype none
// ======================================================================
// bench for the fault protection block
module tb_amp_fault_protection_fault_indicator_pin;
   import afpd_pkg::*;
   localparam int RC = 20;
   logic clk, rst_b, en, bmode, s_off, s_clip, s_warn, start, rd;
   logic fold, hot, warn, lows, highs, clip, st_v, gain, stage;
   logic fpin, foe, spin, soe, fwire, swire;
   logic [NUM_CH-1:0] climit, lshort, sshort, offs, oshort, chon, clim_o;
   logic [NUM_CH*ST_W-1:0] st;
   logic [27:0] q[$];
   logic [27:0] e;
   int errors, cmp_count, ch;
   afpd_top #(.RETRY_CYCLES(RC)) dut (.clock_in(clk), .rst_b_in(rst_b),
      .enable_in(en), .bus_mode_in(bmode), .sel_offset_fault_indicator_pin_in(s_off),
      .sel_clip_in(s_clip), .sel_warn_in(s_warn), .start_req_in(start),
      .temp_fold_in(fold), .temp_hot_in(hot), .temp_warn_in(warn),
      .low_supply_in(lows), .high_supply_in(highs), .clip_in(clip),
      .cur_limit_in(climit), .load_short_in(lshort),
      .supply_short_in(sshort), .offset_in(offs), .out_shorted_in(oshort),
      .status_rd_in(rd), .status_out(st), .status_valid_out(st_v),
      .gain_reduce_out(gain), .stage_on_out(stage), .chan_on_out(chon),
      .cur_limit_out(clim_o), .fault_pin_out(fpin),
      .fault_pin_oe_b_out(foe), .sat_pin_out(spin),
      .sat_pin_oe_b_out(soe));
   afpd_host host (.clock_in(clk), .fault_drv_in(fpin),
      .fault_oe_b_in(foe), .sat_drv_in(spin), .sat_oe_b_in(soe),
      .fault_wire_out(fwire), .sat_wire_out(swire), .rd_out(rd));
   // ===================================================================
   // helpers
   task automatic cmp(input logic [13:0] got, input logic [13:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp
   task automatic close_out;
      $display("errors=%0d comparisons=%0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : close_out
   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask : settle
   // note expected latch word and mask, then read
   task automatic rd_exp(input logic [13:0] v, input logic [13:0] m);
      q.push_back({v, m});
      host.issue_read();
   endtask : rd_exp
   task automatic flush;
      settle(4);
      rd_exp(14'h0000, 14'h0000);
      rd_exp(14'h0000, 14'h0000);
   endtask : flush
   task automatic wait_on(input int lim);
      int i;
      for (i = 0; i < lim && chon !== 2'h3; i++)
         @(negedge clk);
      cmp(i == lim, 1'b0);
   endtask : wait_on
   // ===================================================================
   // status monitor: every valid takes the oldest note
   always @(posedge clk)
   begin
      if (st_v === 1'b1)
      begin
         if (q.size() == 0)
            cmp(14'h3FFF, 14'h0000);
         else
         begin
            e = q.pop_front();
            cmp(st & e[13:0], e[27:14] & e[13:0]);
         end
      end
   end
   // clock and hang guard
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   initial
   begin
      repeat (50000) @(posedge clk);
      errors++;
      close_out();
   end
   // ===================================================================
   // main sequence
   initial
   begin
      // read strobe belongs to the host model alone
      {rst_b, en, bmode, s_off, s_clip, s_warn, start} = 7'h20;
      {fold, hot, warn, lows, highs, clip} = 6'h00;
      {climit, lshort, sshort, offs, oshort} = 10'h000;
      void'($urandom(32'h4806761B));
      ch = $urandom % 2;
      settle(4);
      cmp({fwire, swire}, 2'h0);
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      settle(4);
      cmp({fwire, swire}, 2'h3);
      rd_exp(14'h0000, 14'h3FFF);
      @(posedge clk);
      en <= 1'b0;
      host.issue_read();
      settle(3);
      // short present before start so the synchronised check sees it
      @(posedge clk);
      {en, oshort} <= 3'h5;
      settle(2);
      @(posedge clk);
      start <= 1'b1;
      settle(8);
      cmp({stage, fwire}, 2'h0);
      @(posedge clk);
      oshort <= 2'h0;
      wait_on(20);
      flush();
      @(posedge clk);
      lshort[ch] <= 1'b1;
      settle(5);
      cmp({chon, fwire}, {2'h3 ^ (2'h1 << ch), 1'b0});
      @(posedge clk);
      lshort[ch] <= 1'b0;
      settle(RC / 2);
      cmp(chon, 2'h3 ^ (2'h1 << ch));
      wait_on(RC + 10);
      settle(2);
      cmp(fwire, 1'b1);
      rd_exp(14'h1 << (ch * 7), 14'h1 << (ch * 7));
      rd_exp(14'h0000, 14'h3FFF);
      @(posedge clk);
      sshort[ch] <= 1'b1;
      settle(RC * 2);
      cmp(chon, 2'h3 ^ (2'h1 << ch));
      @(posedge clk);
      sshort[ch] <= 1'b0;
      wait_on(RC + 10);
      @(posedge clk);
      climit <= 2'h3;
      settle(5);
      cmp({chon, clim_o, stage}, 5'h1F);
      @(posedge clk);
      {climit, fold} <= 3'h1;
      settle(4);
      cmp(gain, 1'b1);
      @(posedge clk);
      hot <= 1'b1;
      settle(4);
      cmp({stage, chon, fwire}, 4'h0);
      @(posedge clk);
      {hot, fold} <= 2'h0;
      wait_on(20);
      flush();
      @(posedge clk);
      {bmode, offs[ch]} <= 2'h3;
      settle(5);
      cmp(fwire, 1'b1);
      @(posedge clk);
      s_off <= 1'b1;
      settle(5);
      cmp(fwire, 1'b0);
      rd_exp(14'h4 << (ch * 7), 14'h4 << (ch * 7));
      @(posedge clk);
      {offs, s_off, clip, lows} <= 5'h03;
      settle(5);
      cmp({fwire, swire}, 2'h1);
      @(posedge clk);
      s_clip <= 1'b1;
      settle(5);
      cmp(swire, 1'b0);
      @(posedge clk);
      {lows, clip, s_clip, bmode, warn} <= 5'h01;
      settle(5);
      cmp({fwire, swire}, 2'h2);
      @(posedge clk);
      warn <= 1'b0;
      flush();
      settle(6);
      cmp(14'(q.size()), 14'h0000);
      close_out();
   end
endmodule : tb_amp_fault_protection_fault_indicator_pin
`default_nettype wire
